// *** common/asc_regs.vh ***
// timing constants for the asynchronous static memory controller
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// ******************************
// clock and grade timing, ns
// ******************************
`define ASC_CLK_PERIOD_NS   10
`define ASC_CYCLE_NS_FAST   45
`define ASC_CYCLE_NS_SLOW   55
`define ASC_ACCESS_NS_FAST  45
`define ASC_ACCESS_NS_SLOW  55
`define ASC_GATE_NS_FAST    22
`define ASC_GATE_NS_SLOW    25
`define ASC_AW_NS_FAST      35
`define ASC_AW_NS_SLOW      40
`define ASC_WDS_NS          25
`define ASC_FLOAT_NS_FAST   18
`define ASC_FLOAT_NS_SLOW   20
`define ASC_HOLD_NS         10
`define ASC_RECOV_NS_FAST   45
`define ASC_RECOV_NS_SLOW   55
`define ASC_CDR_NS          0
// ******************************
// derived cycle counts, rounded up
// ******************************
`define ASC_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_CNT_W           4
`endif

// *** logic/asc_timer.v ***
// down counter that flags when a programmed wait has elapsed
`timescale 1ns/10ps
module asc_timer #(
   parameter W = 4
) (
   ref_clk,
   rst_n,
   load,
   load_val,
   done
);
   input  wire         ref_clk;
   input  wire         rst_n;
   input  wire         load;
   input  wire [W-1:0] load_val;
   output wire         done;

   reg [W-1:0] cnt_reg;

   always @(posedge ref_clk)
   begin
      if (!rst_n)
         cnt_reg <= {W{1'b0}};
      else if (load)
         cnt_reg <= load_val;
      else if (cnt_reg != {W{1'b0}})
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
   end

   // done ignores load so the sequencer may reload on it without a loop
   assign done = (cnt_reg == {W{1'b0}});
endmodule // asc_timer

// *** logic/asc_ctrl.v ***
// host controller driving an asynchronous 128k x 8 static memory
`timescale 1ns/10ps
`include "asc_regs.vh"
module asc_ctrl #(
   parameter SLOW_GRADE = 0,
   parameter AW         = 17,
   parameter DW         = 8
) (
   ref_clk,
   rst_n,
   req_valid,
   req_write,
   req_addr,
   req_wdata,
   req_ready,
   rsp_valid,
   rsp_rdata,
   retain_req,
   retain_active,
   mem_addr,
   select_low_active_n,
   select_high_active,
   mem_we_n,
   mem_oe_n,
   mem_dq_in,
   mem_dq_out,
   mem_dq_oe
);
   input  wire          ref_clk;
   input  wire          rst_n;
   input  wire          req_valid;
   input  wire          req_write;
   input  wire [AW-1:0] req_addr;
   input  wire [DW-1:0] req_wdata;
   output reg           req_ready;
   output reg           rsp_valid;
   output reg  [DW-1:0] rsp_rdata;
   input  wire          retain_req;
   output reg           retain_active;
   output reg  [AW-1:0] mem_addr;
   output reg           select_low_active_n;
   output reg           select_high_active;
   output reg           mem_we_n;
   output reg           mem_oe_n;
   input  wire [DW-1:0] mem_dq_in;
   output reg  [DW-1:0] mem_dq_out;
   output reg           mem_dq_oe;

   // ******************************
   // grade timing in clock cycles
   // ******************************
   localparam CW = `ASC_CNT_W;
   localparam integer RD_I  = SLOW_GRADE ? `ASC_CYC(`ASC_ACCESS_NS_SLOW)
                                         : `ASC_CYC(`ASC_ACCESS_NS_FAST);
   localparam integer WR_I  = SLOW_GRADE ?
      `ASC_CYC(`ASC_AW_NS_SLOW + `ASC_FLOAT_NS_SLOW) :
      `ASC_CYC(`ASC_AW_NS_FAST + `ASC_FLOAT_NS_FAST);
   localparam integer FLT_I = SLOW_GRADE ? `ASC_CYC(`ASC_FLOAT_NS_SLOW)
                                         : `ASC_CYC(`ASC_FLOAT_NS_FAST);
   localparam integer CYC_I = SLOW_GRADE ? `ASC_CYC(`ASC_CYCLE_NS_SLOW)
                                         : `ASC_CYC(`ASC_CYCLE_NS_FAST);
   localparam integer REC_I = SLOW_GRADE ? `ASC_CYC(`ASC_RECOV_NS_SLOW)
                                         : `ASC_CYC(`ASC_RECOV_NS_FAST);
   localparam [CW-1:0] RD_CYC  = RD_I[CW-1:0];
   localparam [CW-1:0] WR_CYC  = WR_I[CW-1:0];
   localparam [CW-1:0] FLT_CYC = FLT_I[CW-1:0];
   localparam [CW-1:0] CYC_CYC = CYC_I[CW-1:0];
   localparam [CW-1:0] REC_CYC = REC_I[CW-1:0];
   localparam [CW-1:0] ONE = 4'h1;

   // ******************************
   // states
   // ******************************
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_READ = 3'd1;
   localparam [2:0] ST_WRSU = 3'd2;
   localparam [2:0] ST_WRIT = 3'd3;
   localparam [2:0] ST_GAP  = 3'd4;
   localparam [2:0] ST_RET  = 3'd5;
   localparam [2:0] ST_REC  = 3'd6;

   reg  [2:0]    state_reg;
   reg  [CW-1:0] cyc_reg;
   reg           t_load;
   reg  [CW-1:0] t_val;
   wire          t_done;

   asc_timer #(
      .W        (CW)
   ) u_timer (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .load     (t_load),
      .load_val (t_val),
      .done     (t_done)
   );

   always @*
   begin
      t_load = 1'b0;
      t_val  = {CW{1'b0}};
      case (state_reg)
         ST_IDLE:
         begin
            if (retain_req)
            begin
               t_load = 1'b0;
            end
            else if (req_valid && req_ready)
            begin
               t_load = 1'b1;
               t_val  = req_write ? ONE : RD_CYC - ONE;
            end
         end
         ST_WRSU:
         begin
            t_load = 1'b1;
            t_val  = WR_CYC - ONE;
         end
         ST_READ, ST_WRIT:
         begin
            if (t_done)
            begin
               t_load = 1'b1;
               t_val  = FLT_CYC;
            end
         end
         ST_RET:
         begin
            if (!retain_req)
            begin
               t_load = 1'b1;
               t_val  = REC_CYC;
            end
         end
         default:
         begin
            t_load = 1'b0;
         end
      endcase
   end

   // ******************************
   // sequencer
   // ******************************
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_reg           <= ST_IDLE;
         cyc_reg             <= {CW{1'b0}};
         req_ready           <= 1'b0;
         rsp_valid           <= 1'b0;
         rsp_rdata           <= {DW{1'b0}};
         retain_active       <= 1'b0;
         mem_addr            <= {AW{1'b0}};
         select_low_active_n <= 1'b1;
         select_high_active  <= 1'b0;
         mem_we_n            <= 1'b1;
         mem_oe_n            <= 1'b1;
         mem_dq_out          <= {DW{1'b0}};
         mem_dq_oe           <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (cyc_reg != {CW{1'b0}})
            cyc_reg <= cyc_reg - ONE;
         case (state_reg)
            ST_IDLE:
            begin
               if (retain_req)
               begin
                  // deselect first; retention flagged the cycle after
                  select_low_active_n <= 1'b1;
                  select_high_active  <= 1'b0;
                  req_ready           <= 1'b0;
                  state_reg           <= ST_RET;
               end
               else if (req_valid && req_ready)
               begin
                  req_ready           <= 1'b0;
                  mem_addr            <= req_addr;
                  cyc_reg             <= CYC_CYC - ONE;
                  select_low_active_n <= 1'b0;
                  select_high_active  <= 1'b1;
                  if (req_write)
                  begin
                     mem_oe_n   <= 1'b1;
                     mem_dq_out <= req_wdata;
                     state_reg  <= ST_WRSU;
                  end
                  else
                  begin
                     mem_oe_n  <= 1'b0;
                     state_reg <= ST_READ;
                  end
               end
               else
                  req_ready <= (cyc_reg <= ONE);
            end
            ST_READ:
            begin
               if (t_done)
               begin
                  rsp_rdata           <= mem_dq_in;
                  rsp_valid           <= 1'b1;
                  mem_oe_n            <= 1'b1;
                  select_low_active_n <= 1'b1;
                  select_high_active  <= 1'b0;
                  state_reg           <= ST_GAP;
               end
            end
            ST_WRSU:
            begin
               // address settled with gate high; open the write window
               mem_we_n  <= 1'b0;
               state_reg <= ST_WRIT;
            end
            ST_WRIT:
            begin
               mem_dq_oe <= 1'b1;
               if (t_done)
               begin
                  // strobe ends the write; select and data stay one more cycle
                  mem_we_n  <= 1'b1;
                  state_reg <= ST_GAP;
               end
            end
            ST_GAP:
            begin
               // float data and deselect after the strobe edge
               mem_dq_oe           <= 1'b0;
               select_low_active_n <= 1'b1;
               select_high_active  <= 1'b0;
               if (t_done && cyc_reg <= ONE)
               begin
                  req_ready <= !retain_req;
                  state_reg <= ST_IDLE;
               end
            end
            ST_RET:
            begin
               retain_active <= retain_req;
               if (!retain_req)
                  state_reg <= ST_REC;
            end
            ST_REC:
            begin
               retain_active <= 1'b0;
               if (t_done)
               begin
                  req_ready <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // asc_ctrl

// *** tb/asc_ctrl_monitor.sv ***
// port assertions for the static memory controller
`timescale 1ns/10ps
module asc_ctrl_monitor (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        req_ready,
   input wire logic        retain_req,
   input wire logic        retain_active,
   input wire logic [16:0] mem_addr,
   input wire logic        select_low_active_n,
   input wire logic        select_high_active,
   input wire logic        mem_we_n,
   input wire logic        mem_oe_n,
   input wire logic [7:0]  mem_dq_out,
   input wire logic        mem_dq_oe
);
   // ****
   // checks
   // ****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_we_in_select: assert property (!mem_we_n |-> !select_low_active_n && select_high_active)
      else $error("strobe low while deselected");
   a_no_contend: assert property (mem_dq_oe |-> mem_oe_n)
      else $error("data driven while gate open");
   a_addr_in_write: assert property (!mem_we_n |-> $stable(mem_addr))
      else $error("address moved inside write");
   a_strobe_width: assert property ($fell(mem_we_n) |-> !mem_we_n [*6])
      else $error("write strobe too short");
   a_data_setup: assert property ($rose(mem_we_n) |->
      $past(mem_dq_oe, 3) && mem_dq_oe && $past(mem_dq_out, 3) == mem_dq_out)
      else $error("write data setup short");
   a_addr_setup: assert property ($rose(mem_we_n) |-> $past(mem_addr, 4) == mem_addr)
      else $error("address setup short");
   a_retain_desel: assert property (retain_active |-> select_low_active_n && !select_high_active)
      else $error("selected in retention");
   a_recover_wait: assert property ($fell(retain_req) |-> !req_ready [*5])
      else $error("recovery too short");
   a_cycle_space: assert property ($changed(mem_addr) |=> $stable(mem_addr) [*4])
      else $error("address cycles too close");
endmodule // asc_ctrl_monitor

bind asc_ctrl asc_ctrl_monitor u_asc_ctrl_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
   .req_ready(req_ready), .retain_req(retain_req), .retain_active(retain_active),
   .mem_addr(mem_addr), .select_low_active_n(select_low_active_n),
   .select_high_active(select_high_active), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
   .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// *** tb/asc_sram_model.sv ***
// behavioural 128k x 8 static memory
`timescale 1ns/10ps
module asc_sram_model #(
   parameter ACC_NS = 45
) (
   input wire logic [16:0] mem_addr,
   input wire logic        select_low_active_n,
   input wire logic        select_high_active,
   input wire logic        mem_we_n,
   input wire logic        mem_oe_n,
   input wire logic [7:0]  mem_dq_out,
   input wire logic        mem_dq_oe,
   output logic [7:0]      mem_dq_in
);
   // ****
   // storage and read path
   // ****
   logic [7:0] mem_q [0:131071];
   wire        sel    = !select_low_active_n && select_high_active;
   wire        wr_win = sel && !mem_we_n;
   wire        rd     = sel && mem_we_n && !mem_oe_n;
   initial mem_dq_in = 8'h5A;
   // data taken at whichever edge closes the window
   always @(negedge wr_win) mem_q[mem_addr] = mem_dq_oe ? mem_dq_out : ~mem_dq_out;
   always @(mem_addr or rd)
   begin
      mem_dq_in <= #10 ~mem_dq_in;
      if (rd)
         mem_dq_in <= #ACC_NS mem_q[mem_addr];
   end
endmodule // asc_sram_model

// *** tb/asc_ctrl_tb.sv ***
// self-checking bench for the static memory controller
`timescale 1ns/10ps
`include "asc_regs.vh"
module asc_ctrl_tb;
   logic        ref_clk, rst_n, req_valid, req_write, retain_req;
   logic [16:0] req_addr;
   logic [7:0]  req_wdata;
   wire         req_ready, rsp_valid, retain_active, sel_n, sel_h, we_n, oe_n, dq_oe;
   wire  [7:0]  rsp_rdata, dq_out, dev_dq, dq_in;
   wire  [16:0] mem_addr;
   int          err_total, check_count;
   assign dq_in = dq_oe ? dq_out : dev_dq;
   asc_ctrl u_asc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .retain_req(retain_req), .retain_active(retain_active), .mem_addr(mem_addr),
      .select_low_active_n(sel_n), .select_high_active(sel_h), .mem_we_n(we_n),
      .mem_oe_n(oe_n), .mem_dq_in(dq_in), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe));
   asc_sram_model u_asc_sram_model (.mem_addr(mem_addr), .select_low_active_n(sel_n),
      .select_high_active(sel_h), .mem_we_n(we_n), .mem_oe_n(oe_n),
      .mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(dev_dq));
   // ****
   // tasks
   // ****
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wait_ready(output int n);
      n = 0;
      while (req_ready !== 1'b1 && n < 50)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic do_op(input logic wr, input logic [16:0] a, input logic [7:0] d);
      int n;
      wait_ready(n);
      check("ready", {31'd0, req_ready}, 1);
      req_valid = 1'b1;
      req_write = wr;
      req_addr  = a;
      req_wdata = d;
      @(negedge ref_clk);
      req_valid = 1'b0;
      n = 0;
      while (!wr && rsp_valid !== 1'b1 && n < 20)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (!wr)
      begin
         check("rd_latency", n, `ASC_CYC(`ASC_ACCESS_NS_FAST));
         check("rd_data", {24'd0, rsp_rdata}, {24'd0, d});
      end
   endtask
   task automatic t_write_read;
      do_op(1'b1, 17'h0_0000, 8'h00);
      do_op(1'b1, 17'h1_FFFF, 8'hFF);
      do_op(1'b1, 17'h0_AA55, 8'h5A);
      do_op(1'b1, 17'h0_AA55, 8'hA5);
      do_op(1'b0, 17'h1_FFFF, 8'hFF);
      do_op(1'b0, 17'h0_0000, 8'h00);
      do_op(1'b0, 17'h0_AA55, 8'hA5);
   endtask
   task automatic t_retain;
      int n;
      wait_ready(n);
      retain_req = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("retain", {sel_n, sel_h, retain_active, req_ready}, 4'b1010);
      retain_req = 1'b0;
      wait_ready(n);
      check("recovery", {31'd0, n >= `ASC_CYC(`ASC_RECOV_NS_FAST)}, 1);
      do_op(1'b0, 17'h1_FFFF, 8'hFF);
   endtask
   // ****
   // sequence
   // ****
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      #100us;
      err_total++;
      report_and_stop;
   end
   initial
   begin
      {rst_n, req_valid, req_write, retain_req, req_addr, req_wdata} = '0;
      repeat (2) @(negedge ref_clk);
      check("reset_pins", {sel_n, sel_h, we_n, oe_n, dq_oe, req_ready}, 6'b101100);
      rst_n = 1'b1;
      t_write_read;
      t_retain;
      report_and_stop;
   end
endmodule // asc_ctrl_tb
